// ===== core/socket_ext_regs.sv
// per-socket chip select, dma and drive option registers
// assumes a same-clock register port and pin inputs from outside
//
// Overview of operation
// - eight-bit base compares address per space
// - two-bit size code sets block size
// - shared status irq pulses low four cycles
// - share bit picks level or open-drain pulse
// - dma mode bit reinterprets config bits
// - request steering and dma width select
// - terminal count steered per two-bit code
// - dma enabled only for dma card
// - ata bit drives gp outputs on address
// - ata clear passes normal card address
// - float bit seven on drive port reads
// - float clear in both sockets drives bit seven normally
// - bvd2 as speaker or led input
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`include "socket_ext_defines.svh"
module socket_ext_regs (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  input wire logic [23:0] hostAddr,
  input wire logic hostMemCycle,
  input wire logic hostIoRead,
  input wire logic hostIoCycle,
  input wire logic [1:0] statusChange,
  input wire logic [1:0] cardIsDma,
  input wire logic [1:0] cardIoMode,
  input wire logic [1:0] dmaRead,
  input wire logic [1:0] pinIois16,
  input wire logic [1:0] pinSpkr,
  input wire logic [1:0] pinInpack,
  input wire logic [1:0] pinBvd2,
  input wire logic [9:0] normalCardAddr,
  output logic [1:0] statusIrq,
  output logic [1:0] statusIrqOe,
  output logic [1:0] chipSelect,
  output logic [1:0] dmaReq,
  output logic [1:0] dmaEnable,
  output logic [1:0] dma16,
  output logic [1:0] tcWe,
  output logic [1:0] tcOe,
  output logic [1:0] speakerIn,
  output logic [1:0] ledIn,
  output logic [9:0] cardAddrHi,
  output logic hostBit7Oe,
  output logic irq
);
  import socket_ext_pkg::*;
  // every check below runs on the core clock, quiet during reset
  default clocking assertClk @(posedge core_clk);
  endclocking
  default disable iff (rst);

  state_t cur; // registered state
  state_t next_cur; // next state
  // pin synchronisers; first stage read only by second
  logic [11:0] syncA;
  logic [11:0] syncB;
  logic [9:0] normAddr; // same-clock, no sync needed

  // base compare: mask address bits inside the block
  function automatic logic baseMatch(input logic [7:0] base,
      input logic [7:0] addrBits, input logic [1:0] size);
    logic [7:0] mask;
    mask = 8'hff << size;
    baseMatch = ((base ^ addrBits) & mask) == 8'h00;
  endfunction

  // two-flop sync of card pins
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      syncA <= 12'h000;
      syncB <= 12'h000;
    end else begin
      syncA <= {pinIois16, pinSpkr, pinInpack, pinBvd2,
                cardIsDma, dmaRead};
      syncB <= syncA;
    end
  end
  assign normAddr = normalCardAddr;

  // next state
  always_comb begin
    logic [1:0] iois;
    logic [1:0] spk;
    logic [1:0] inp;
    logic [1:0] bvd;
    logic [1:0] isDma;
    logic [1:0] dRd;
    logic [7:0] rd;
    logic dmaMode;
    logic [7:0] cfgNew;
    next_cur = cur;
    {iois, spk, inp, bvd, isDma, dRd} = syncB;
    rd = 8'h00;
    cfgNew = 8'h00;
    dmaMode = 1'b0;
    next_cur.bit7Oe = 1'b1;
    // register writes
    if (regWr) begin
      case (regAddr)
        `OFS_A_CS_BASE: next_cur.sock[0].csBase = regWrData;
        `OFS_A_CFG: next_cur.sock[0].cfg = regWrData;
        `OFS_A_DRIVE: next_cur.sock[0].drive = regWrData;
        `OFS_B_CS_BASE: next_cur.sock[1].csBase = regWrData;
        `OFS_B_CFG: next_cur.sock[1].cfg = regWrData;
        `OFS_B_DRIVE: next_cur.sock[1].drive = regWrData;
        `OFS_IRQ_MASK: next_cur.irqMask = regWrData[1:0];
        default: ;
      endcase
    end
    // register reads; unmapped reads return zero
    if (regRd) begin
      case (regAddr)
        `OFS_A_CS_BASE: rd = cur.sock[0].csBase;
        `OFS_A_CFG: rd = cur.sock[0].cfg;
        `OFS_A_DRIVE: rd = cur.sock[0].drive;
        `OFS_B_CS_BASE: rd = cur.sock[1].csBase;
        `OFS_B_CFG: rd = cur.sock[1].cfg;
        `OFS_B_DRIVE: rd = cur.sock[1].drive;
        `OFS_IRQ_STATUS: rd = {6'h00, cur.irqStatus};
        `OFS_IRQ_MASK: rd = {6'h00, cur.irqMask};
        default: rd = 8'h00;
      endcase
    end
    next_cur.rdData = rd;
    // read clears status; fresh events below win
    if (regRd && regAddr == `OFS_IRQ_STATUS)
      next_cur.irqStatus = 2'b00;
    // per-socket logic
    for (int s = 0; s < 2; s++) begin
      cfgNew = cur.sock[s].cfg;
      dmaMode = cfgNew[`CFG_DMA_MODE];
      if (statusChange[s])
        next_cur.irqStatus[s] = 1'b1;
      // status irq shaping
      if (cfgNew[`CFG_IRQ_SHARE]) begin
        if (statusChange[s])
          next_cur.sock[s].pulseCount = `PULSE_CYCLES;
        else if (cur.sock[s].pulseCount != 3'h0)
          next_cur.sock[s].pulseCount = cur.sock[s].pulseCount - 3'h1;
        // low while counting; released otherwise
        next_cur.statusIrq[s] = 1'b0;
        next_cur.statusIrqOe[s] =
          statusChange[s] || cur.sock[s].pulseCount > 3'h1;
      end else begin
        next_cur.sock[s].pulseCount = 3'h0;
        next_cur.statusIrq[s] = next_cur.irqStatus[s];
        next_cur.statusIrqOe[s] = 1'b1;
      end
      // chip select decode, only outside dma interpretation
      next_cur.chipSelect[s] = 1'b0;
      if (!dmaMode) begin
        if (cfgNew[`CFG_SPACE])
          next_cur.chipSelect[s] = hostIoCycle &&
            hostAddr[23:10] == 14'h0000 &&
            baseMatch(cur.sock[s].csBase, hostAddr[9:2],
                      cfgNew[6:5]);
        else
          next_cur.chipSelect[s] = hostMemCycle &&
            baseMatch(cur.sock[s].csBase, hostAddr[23:16],
                      cfgNew[6:5]);
      end
      // dma settings
      next_cur.dmaEnable[s] = dmaMode && isDma[s];
      next_cur.dma16[s] = dmaMode && cfgNew[4];
      case (cfgNew[6:5])
        2'b00: next_cur.dmaReq[s] = dmaMode && iois[s];
        2'b01: next_cur.dmaReq[s] = dmaMode && spk[s];
        2'b10: next_cur.dmaReq[s] = dmaMode && inp[s];
        default: next_cur.dmaReq[s] = 1'b0;
      endcase
      case (cfgNew[2:1])
        2'b00: begin
          next_cur.tcWe[s] = dmaMode && dRd[s];
          next_cur.tcOe[s] = dmaMode && !dRd[s];
        end
        2'b01: begin
          next_cur.tcWe[s] = dmaMode;
          next_cur.tcOe[s] = 1'b0;
        end
        2'b10: begin
          next_cur.tcWe[s] = 1'b0;
          next_cur.tcOe[s] = dmaMode;
        end
        default: begin
          next_cur.tcWe[s] = 1'b0;
          next_cur.tcOe[s] = 1'b0;
        end
      endcase
      // bvd2 interpretation in io mode
      next_cur.speakerIn[s] = cardIoMode[s] &&
        !cur.sock[s].drive[`DRV_BVD_LED] && bvd[s];
      next_cur.ledIn[s] = cardIoMode[s] &&
        cur.sock[s].drive[`DRV_BVD_LED] && bvd[s];
      // upper card address lines
      if (cur.sock[s].drive[`DRV_ATA])
        next_cur.cardAddrHi[s*5 +: 5] = cur.sock[s].drive[7:3];
      else
        next_cur.cardAddrHi[s*5 +: 5] = normAddr[s*5 +: 5];
      // float host bit seven on drive port reads
      if (cur.sock[s].drive[`DRV_FLOAT7] && hostIoRead &&
          (hostAddr[9:0] == `DRIVE_PORT_HI ||
           hostAddr[9:0] == `DRIVE_PORT_LO))
        next_cur.bit7Oe = 1'b0;
    end
    // otherwise bit seven stays driven
    next_cur.irq = |(next_cur.irqStatus & next_cur.irqMask);
  end

  // state register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst)
      cur <= '0;
    else
      cur <= next_cur;
  end

  // outputs straight from flops
  assign regRdData = cur.rdData;
  assign statusIrq = cur.statusIrq;
  assign statusIrqOe = cur.statusIrqOe;
  assign chipSelect = cur.chipSelect;
  assign dmaReq = cur.dmaReq;
  assign dmaEnable = cur.dmaEnable;
  assign dma16 = cur.dma16;
  assign tcWe = cur.tcWe;
  assign tcOe = cur.tcOe;
  assign speakerIn = cur.speakerIn;
  assign ledIn = cur.ledIn;
  assign cardAddrHi = cur.cardAddrHi;
  assign hostBit7Oe = cur.bit7Oe;
  assign irq = cur.irq;

  // assertions, clocked and disabled by the defaults above
  // shared pulse holds four cycles, socket a
  pulse_len_a_a: assert property (
    $rose(statusIrqOe[0]) && cur.sock[0].cfg[3] |-> statusIrqOe[0][*4])
    else $error("shared irq pulse too short");
  // shared pulse holds four cycles, socket b
  pulse_len_b_a: assert property (
    $rose(statusIrqOe[1]) && cur.sock[1].cfg[3] |-> statusIrqOe[1][*4])
    else $error("shared irq pulse too short on b");
  // level mode keeps the pin driven
  level_mode_a: assert property (
    !cur.sock[0].cfg[3] |=> statusIrqOe[0])
    else $error("level irq not driven");
  // level mode keeps the pin driven, socket b
  level_mode_b_a: assert property (
    !cur.sock[1].cfg[3] |=> statusIrqOe[1])
    else $error("level irq not driven on b");
  // shared mode only ever pulls low
  share_low_a: assert property (
    cur.sock[0].cfg[3] |=> !statusIrq[0])
    else $error("shared irq driven high");
  // shared mode only ever pulls low, socket b
  share_low_b_a: assert property (
    cur.sock[1].cfg[3] |=> !statusIrq[1])
    else $error("shared irq driven high on b");
  // level output follows the sticky status bit
  level_follow_a: assert property (
    !cur.sock[0].cfg[3] |=> statusIrq[0] == cur.irqStatus[0])
    else $error("level irq not following status");
  // pulse ends once the count runs out
  pulse_end_a: assert property (
    cur.sock[0].cfg[3] && cur.sock[0].pulseCount == 3'h1 &&
    !statusChange[0] |=> !statusIrqOe[0]) else $error("shared pulse stuck");
  // dma enable needs the mode bit
  dma_gate_a: assert property (
    dmaEnable[0] |-> $past(cur.sock[0].cfg[0]))
    else $error("dma enabled without mode bit");
  // dma enable needs the mode bit, socket b
  dma_gate_b_a: assert property (
    dmaEnable[1] |-> $past(cur.sock[1].cfg[0]))
    else $error("dma enabled without mode bit on b");
  // no chip select while in dma interpretation
  cs_dma_a: assert property (
    chipSelect[1] |-> !$past(cur.sock[1].cfg[0]))
    else $error("chip select in dma mode");
  // no chip select while in dma interpretation, socket a
  cs_dma_a_a: assert property (
    chipSelect[0] |-> !$past(cur.sock[0].cfg[0]))
    else $error("chip select in dma mode on a");
  // code three silences terminal count
  tc_off_a: assert property (
    $past(cur.sock[0].cfg[2:1]) == 2'b11 |-> !tcWe[0] && !tcOe[0])
    else $error("terminal count not disabled");
  // code three silences terminal count, socket b
  tc_off_b_a: assert property (
    $past(cur.sock[1].cfg[2:1]) == 2'b11 |-> !tcWe[1] && !tcOe[1])
    else $error("terminal count not disabled on b");
  // ata bit puts the gp bits on the address lines
  gp_out_a: assert property (
    cur.sock[0].drive[0] |=> cardAddrHi[4:0] == $past(cur.sock[0].drive[7:3]))
    else $error("gp outputs not on address");
  // ata bit puts the gp bits on the address lines, socket b
  gp_out_b_a: assert property (
    cur.sock[1].drive[0] |=> cardAddrHi[9:5] == $past(cur.sock[1].drive[7:3]))
    else $error("gp outputs not on address on b");
  // ata clear passes the ordinary address
  addr_pass_a: assert property (
    !cur.sock[0].drive[0] |=> cardAddrHi[4:0] == $past(normalCardAddr[4:0]))
    else $error("card address not passed");
  // ata clear passes the ordinary address, socket b
  addr_pass_b_a: assert property (
    !cur.sock[1].drive[0] |=> cardAddrHi[9:5] == $past(normalCardAddr[9:5]))
    else $error("card address not passed on b");
  // float only after a host read; reset leaves it low once
  float_bit7_a: assert property (
    !hostBit7Oe && !$past(rst) |-> $past(hostIoRead))
    else $error("bit seven floated outside read");
  // with both float options clear bit seven stays driven
  drive_bit7_a: assert property (
    !$past(rst) && !$past(cur.sock[0].drive[2] || cur.sock[1].drive[2])
    |-> hostBit7Oe) else $error("bit seven floated with option clear");
  // memory chip select only on memory cycles
  mem_cs_a: assert property (
    chipSelect[0] && !$past(cur.sock[0].cfg[4]) |-> $past(hostMemCycle))
    else $error("memory chip select without cycle");
  // memory chip select only on memory cycles, socket b
  mem_cs_b_a: assert property (
    chipSelect[1] && !$past(cur.sock[1].cfg[4]) |-> $past(hostMemCycle))
    else $error("memory chip select without cycle on b");
  // io chip select only on io cycles
  io_cs_a: assert property (
    chipSelect[0] && $past(cur.sock[0].cfg[4]) |-> $past(hostIoCycle))
    else $error("io chip select without cycle");
  // smallest memory block must match the whole base
  base_cs_a: assert property (chipSelect[0] &&
    $past(cur.sock[0].cfg[6:4]) == 3'b000 |->
    $past(hostAddr[23:16] == cur.sock[0].csBase))
    else $error("chip select without base match");
  // wide dma needs width and mode bits
  dma_width_a: assert property (
    dma16[1] |-> $past(cur.sock[1].cfg[4]) && $past(cur.sock[1].cfg[0]))
    else $error("wide dma without setting");
  // wide dma needs width and mode bits, socket a
  dma_width_a_a: assert property (
    dma16[0] |-> $past(cur.sock[0].cfg[4]) && $past(cur.sock[0].cfg[0]))
    else $error("wide dma without setting on a");
  // reserved steering code never raises a request
  dma_req_a: assert property (
    dmaReq[0] |-> $past(cur.sock[0].cfg[0] && cur.sock[0].cfg[6:5] != 2'b11))
    else $error("dma request without valid steering");
  // speaker path only in io mode with led select clear
  speaker_sel_a: assert property (
    speakerIn[0] |-> $past(cardIoMode[0] && !cur.sock[0].drive[1]))
    else $error("speaker input outside its mode");
  // led path only in io mode with led select set
  led_sel_a: assert property (
    ledIn[0] |-> $past(cardIoMode[0] && cur.sock[0].drive[1]))
    else $error("led input outside its mode");
  // sticky status survives until its register is read
  status_hold_a: assert property (
    $past(cur.irqStatus[0] && !(regRd && regAddr == `OFS_IRQ_STATUS))
    |-> cur.irqStatus[0]) else $error("status bit lost before read");
  // read data stands only after a read strobe
  read_idle_a: assert property (
    !$past(regRd) |-> regRdData == 8'h00)
    else $error("read data without read");
  // automatic steering uses write enable only on dma reads
  tc_auto_a: assert property (
    tcWe[0] && $past(cur.sock[0].cfg[2:1] == 2'b00) |-> $past(syncB[0]))
    else $error("terminal count on write enable for dma write");
endmodule // socket_ext_regs

// ===== inc/socket_ext_defines.svh
// offsets, field positions, reset values and timing counts
// assumes inclusion by bare name from design files
`ifndef SOCKET_EXT_DEFINES_SVH
`define SOCKET_EXT_DEFINES_SVH
`define OFS_A_CS_BASE 8'h3d
`define OFS_A_CFG 8'h3e
`define OFS_A_DRIVE 8'h3f
`define OFS_B_CS_BASE 8'h7d
`define OFS_B_CFG 8'h7e
`define OFS_B_DRIVE 8'h7f
`define OFS_IRQ_STATUS 8'h40
`define OFS_IRQ_MASK 8'h41
`define RESET_BYTE 8'h00
`define CFG_DMA_MODE 0
`define CFG_IRQ_SHARE 3
`define CFG_SPACE 4
`define DRV_ATA 0
`define DRV_BVD_LED 1
`define DRV_FLOAT7 2
`define PULSE_CYCLES 3'h4
`define DRIVE_PORT_HI 10'h3f7
`define DRIVE_PORT_LO 10'h377
`endif

// ===== inc/socket_ext_pkg.sv
// types shared by the socket extension register block
// assumes the defines header is compiled alongside
package socket_ext_pkg;
  // per-socket register contents
  typedef struct packed {
    logic [7:0] csBase;
    logic [7:0] cfg;
    logic [7:0] drive;
    logic [2:0] pulseCount;
  } socket_t;
  // whole block state
  typedef struct packed {
    socket_t [1:0] sock;
    logic [1:0] irqStatus;
    logic [1:0] irqMask;
    logic [7:0] rdData;
    logic [1:0] statusIrq;
    logic [1:0] statusIrqOe;
    logic [1:0] chipSelect;
    logic [1:0] dmaReq;
    logic [1:0] dmaEnable;
    logic [1:0] dma16;
    logic [1:0] tcWe;
    logic [1:0] tcOe;
    logic [1:0] speakerIn;
    logic [1:0] ledIn;
    logic [9:0] cardAddrHi;
    logic bit7Oe;
    logic irq;
  } state_t;
endpackage

// ===== test/card_socket_model.sv
// card side of one socket pair: dma request, bvd2 and cycle direction
// assumes the bench changes its controls just after a clock edge
`timescale 1ns/1ps
module card_socket_model (
  input wire logic req,
  input wire logic [1:0] reqPin,
  input wire logic isDma,
  input wire logic rdDir,
  input wire logic bvd2,
  output logic [1:0] pinIois16,
  output logic [1:0] pinSpkr,
  output logic [1:0] pinInpack,
  output logic [1:0] pinBvd2,
  output logic [1:0] cardIsDma,
  output logic [1:0] dmaRead
);
  // request on the chosen pin, its inverse on the others,
  // so a wrong steering code shows as a wrong level
  always_comb begin
    pinIois16 = {2{reqPin == 2'h0 ? req : ~req}};
    pinSpkr = {2{reqPin == 2'h1 ? req : ~req}};
    pinInpack = {2{reqPin == 2'h2 ? req : ~req}};
    pinBvd2 = {2{bvd2}};
    cardIsDma = {2{isDma}};
    dmaRead = {2{rdDir}};
  end
endmodule // card_socket_model

// ===== test/tb_top.sv
// self-checking bench for the socket extension registers
// assumes the card model drives all socket pins
`timescale 1ns/1ps
`include "socket_ext_defines.svh"
module tb_top;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] regAddr, regWrData, regRdData, rdv;
  logic regWr, regRd, hostMemCycle, hostIoRead, hostIoCycle, irq;
  logic req, isDma, rdDir, bvd2, hostBit7Oe;
  logic [23:0] hostAddr;
  logic [1:0] statusChange, cardIoMode, reqPin, pinIois16, pinSpkr;
  logic [1:0] pinInpack, pinBvd2, cardIsDma, dmaRead, statusIrq, tcWe;
  logic [1:0] statusIrqOe, chipSelect, dmaReq, dmaEnable, dma16, tcOe;
  logic [1:0] speakerIn, ledIn;
  logic [9:0] normalCardAddr, cardAddrHi;
  int fails = 0;
  int checkCount = 0;
  int cycles = 0;
  int n;
  always #2.5 core_clk = ~core_clk;
  card_socket_model far (.*);
  socket_ext_regs dut (.*);
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    checkCount++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one-cycle strobes, released at the next edge
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge core_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a);
    @(posedge core_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 rdv = regRdData;
  endtask
  // covers the two-flop input sync plus the output register
  task automatic settle;
    repeat (4) @(posedge core_clk);
    #1;
  endtask
  task automatic host(logic [23:0] a, logic m, logic io, logic r);
    @(posedge core_clk);
    hostAddr <= a;
    hostMemCycle <= m;
    hostIoCycle <= io;
    hostIoRead <= r;
    settle;
  endtask
  task automatic event_a;
    @(posedge core_clk);
    statusChange <= 2'h1;
    @(posedge core_clk);
    statusChange <= 2'h0;
  endtask
  task automatic test_regs;
    logic [7:0] ofs [6] = '{8'h3d, 8'h3e, 8'h3f, 8'h7d, 8'h7e, 8'h7f};
    foreach (ofs[i]) begin
      rd(ofs[i]);
      chk("reset", 8'h00, rdv);
      wr(ofs[i], 8'ha5 ^ 8'(i));
      rd(ofs[i]);
      chk("readback", 8'ha5 ^ 8'(i), rdv);
      wr(ofs[i], 8'h00);
    end
    wr(`OFS_IRQ_STATUS, 8'hff);
    rd(`OFS_IRQ_STATUS);
    chk("status ro", 8'h00, rdv);
    rd(8'h10);
    chk("unmapped", 8'h00, rdv);
  endtask
  task automatic test_cs;
    wr(`OFS_A_CS_BASE, 8'h12);
    host(24'h123456, 1'b1, 1'b0, 1'b0);
    chk("cs mem", 8'h01, chipSelect[0]);
    host(24'h130000, 1'b1, 1'b0, 1'b0);
    chk("cs 64k", 8'h00, chipSelect[0]);
    wr(`OFS_A_CFG, 8'h60);
    host(24'h17ffff, 1'b1, 1'b0, 1'b0);
    chk("cs 512k in", 8'h01, chipSelect[0]);
    host(24'h180000, 1'b1, 1'b0, 1'b0);
    chk("cs 512k out", 8'h00, chipSelect[0]);
    wr(`OFS_A_CFG, 8'h10);
    wr(`OFS_A_CS_BASE, 8'h5c);
    host(24'h000171, 1'b0, 1'b1, 1'b0);
    chk("cs io", 8'h01, chipSelect[0]);
    host(24'h000171, 1'b1, 1'b0, 1'b0);
    chk("cs space", 8'h00, chipSelect[0]);
    wr(`OFS_A_CFG, 8'h00);
  endtask
  task automatic test_dma;
    logic [1:0] tcExp [4] = '{2'b10, 2'b10, 2'b01, 2'b00};
    isDma <= 1'b1;
    wr(`OFS_A_CFG, 8'h01);
    settle;
    chk("dma enable", 8'h01, dmaEnable[0]);
    for (int k = 0; k < 3; k++) begin
      wr(`OFS_A_CFG, {1'b0, 2'(k), 1'b1, 4'h7});
      for (int l = 0; l < 2; l++) begin
        @(posedge core_clk);
        req <= 1'(l);
        reqPin <= 2'(k);
        settle;
        chk("dma req", 8'(l), dmaReq[0]);
        chk("dma width", 8'h01, dma16[0]);
      end
    end
    @(posedge core_clk);
    rdDir <= 1'b1;
    for (int t = 0; t < 4; t++) begin
      wr(`OFS_A_CFG, {5'h0, 2'(t), 1'b1});
      settle;
      chk("tc", 8'(tcExp[t]), {tcWe[0], tcOe[0]});
    end
    @(posedge core_clk);
    rdDir <= 1'b0;
    wr(`OFS_A_CFG, 8'h01);
    settle;
    chk("tc write", 8'h01, {tcWe[0], tcOe[0]});
    @(posedge core_clk);
    isDma <= 1'b0;
    settle;
    chk("dma off card", 8'h00, dmaEnable[0]);
    @(posedge core_clk);
    isDma <= 1'b1;
    wr(`OFS_A_CFG, 8'h00);
    settle;
    chk("dma off mode", 8'h00, dmaEnable[0]);
  endtask
  task automatic test_irq;
    wr(`OFS_IRQ_MASK, 8'h01);
    event_a;
    settle;
    chk("irq", 8'h01, irq);
    chk("level", 8'h03, {statusIrq[0], statusIrqOe[0]});
    rd(`OFS_IRQ_STATUS);
    chk("status", 8'h01, rdv);
    settle;
    chk("irq clear", 8'h00, irq);
    wr(`OFS_IRQ_MASK, 8'h00);
    event_a;
    settle;
    chk("irq masked", 8'h00, irq);
    rd(`OFS_IRQ_STATUS);
    chk("status masked", 8'h01, rdv);
    wr(`OFS_A_CFG, 8'h08);
    event_a;
    n = 0;
    repeat (12) begin
      #1 n += int'(statusIrqOe[0] && !statusIrq[0]);
      @(posedge core_clk);
    end
    chk("pulse cycles", 8'h04, 8'(n));
    rd(`OFS_IRQ_STATUS);
    wr(`OFS_A_CFG, 8'h00);
  endtask
  task automatic test_ata;
    cardIoMode <= 2'h1;
    normalCardAddr <= 10'h2aa;
    bvd2 <= 1'b1;
    wr(`OFS_A_DRIVE, 8'ha9);
    settle;
    chk("gp out", 8'h15, cardAddrHi[4:0]);
    chk("speaker", 8'h01, {ledIn[0], speakerIn[0]});
    wr(`OFS_A_DRIVE, 8'h02);
    settle;
    chk("card addr", 8'h0a, cardAddrHi[4:0]);
    chk("led", 8'h02, {ledIn[0], speakerIn[0]});
    wr(`OFS_A_DRIVE, 8'h04);
    host(24'h0003f7, 1'b0, 1'b1, 1'b1);
    chk("float hi", 8'h00, hostBit7Oe);
    host(24'h000377, 1'b0, 1'b1, 1'b1);
    chk("float lo", 8'h00, hostBit7Oe);
    wr(`OFS_A_DRIVE, 8'h00);
    settle;
    chk("drive bit7", 8'h01, hostBit7Oe);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checkCount, fails);
    if (fails == 0 && checkCount > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // hang guard, far above the few hundred cycles needed
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      final_report;
    end
  end
  initial begin
    {regAddr, regWrData, regWr, regRd, hostAddr, hostMemCycle} = '0;
    {hostIoRead, hostIoCycle, statusChange, cardIoMode} = '0;
    {req, reqPin, isDma, rdDir, bvd2, normalCardAddr} = '0;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    test_regs;
    test_cs;
    test_dma;
    test_irq;
    test_ata;
    final_report;
  end
endmodule // tb_top
